// *** common/clock_gen_unit_pkg.sv ***
// clock generator mode and ratio configuration constants
// assumes a simple word-addressed register port, one clock domain
//
// Notes on behaviour
// - multiplier select bits 6:4 decode to 4,6,8,...,18.
// - divider select bits 2:0 decode to 1,2,4,...,128.
// - self-clocked output is loop oscillator clock divided by divider.
// - bypass external output is external clock divided by divider, loop unused.
// - locked internal output is internal reference /7 *64 *mult /div.
// - locked external output is ext *P *mult /div; P=64 low range, 1 high.
// - bus clock is half the generator output.
// - after reset the block runs self-clocked, about 8 MHz out.
// - mode control bit 6 picks range; 0 means low range, prescale 64.
// - mode request bits 4:3 equal 11 select locked external.
// - mode control bit 0 always reads zero.
// - mode control bit 5 requests the crystal oscillator.
// - lock-loss reset enable low means lock loss raises interrupt.
// - clock-loss reset enable low means clock loss raises interrupt.
// - first status register read-only except writing with bit 0 set clears interrupt flag.
// - loop filter value 11:0 adjusts itself; bits 15:12 read zero.
// - locked internal keeps internal reference and loop oscillator on.
// - self-clocked runs loop oscillator open loop, internal reference off.
// - bypass external turns internal reference and loop oscillator off.
// - mode codes 00 self, 01 locked int, 10 bypass ext, 11 locked ext.
// - actual mode follows a request only several cycles later, when conditions hold; clock loss drops it to self at once.
package clock_gen_unit_pkg;

    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_MODE_CTRL = 3'h0;
    localparam logic [2:0] OFS_RATIO_CTRL = 3'h1;
    localparam logic [2:0] OFS_STATUS1 = 3'h2;
    localparam logic [2:0] OFS_STATUS2 = 3'h3;
    localparam logic [2:0] OFS_FILTER_HI = 3'h4;
    localparam logic [2:0] OFS_FILTER_LO = 3'h5;
    localparam logic [2:0] OFS_TRIM = 3'h6;

    // mode control fields
    localparam int MC_HIGH_GAIN = 7;
    localparam int MC_RANGE = 6;
    localparam int MC_EXT_REF = 5;
    localparam int MC_MODE_HI = 4;
    localparam int MC_MODE_LO = 3;
    localparam int MC_KEEP_STOP = 2;
    localparam int MC_LOSS_OFF = 1;
    // ratio control fields
    localparam int RC_LOCK_RST = 7;
    localparam int RC_MULT_HI = 6;
    localparam int RC_MULT_LO = 4;
    localparam int RC_CLK_RST = 3;
    localparam int RC_DIV_HI = 2;
    localparam int RC_DIV_LO = 0;
    // status 1 and status 2 fields
    localparam int S1_MODE_HI = 7;
    localparam int S1_MODE_LO = 6;
    localparam int S1_EXT_OK = 5;
    localparam int S1_CLK_LOST = 4;
    localparam int S1_LOCKED = 3;
    localparam int S1_LOCK_LOST = 2;
    localparam int S1_REF_STABLE = 1;
    localparam int S1_IRQ = 0;
    localparam int S2_OSC_STABLE = 0;

    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] RATIO_CTRL_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [11:0] FILTER_RST = 12'h000;
    localparam logic [7:0] MODE_CTRL_RD_MASK = 8'hfe;

    localparam int REF_OSC_DIVISOR = 7;
    localparam int LOW_RANGE_PRESCALE = 64;
    localparam int HIGH_RANGE_PRESCALE = 1;
    localparam int MULT_BASE = 4;
    localparam int MULT_STEP = 2;

    // settling time before actual mode follows request
    localparam int SETTLE_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_SELF = 2'b00,
        MODE_LOCK_INT = 2'b01,
        MODE_BYPASS_EXT = 2'b10,
        MODE_LOCK_EXT = 2'b11
    } clk_mode_t;

endpackage : clock_gen_unit_pkg

// *** dv/clock_gen_unit_props.sv ***
// checker: port-level properties of clock_gen_unit
// assumes one clock domain, bound from the foot of this file
`timescale 1ns/100ps
module clock_gen_unit_chk
    import clock_gen_unit_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] mode_actual,
    input wire logic [4:0] mult_factor,
    input wire logic [7:0] div_factor,
    input wire logic ref_osc_on,
    input wire logic digital_ctrl_osc_on,
    input wire logic bus_div_half,
    input wire logic irq_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic clr;
    assign clr = reg_write && reg_addr == OFS_STATUS1;
    sequence s_ratio_wr;
        reg_write && reg_addr == OFS_RATIO_CTRL;
    endsequence
    sequence s_held(logic [1:0] m);
        (mode_actual == m) [*2];
    endsequence
    property p_mult;
        s_ratio_wr |-> ##2 mult_factor == 5'(4 + 2 * $past(reg_wdata[6:4], 2));
    endproperty
    property p_div;
        s_ratio_wr |-> ##2 div_factor == 8'(1 << $past(reg_wdata[2:0], 2));
    endproperty
    property p_bit0;
        reg_read && reg_addr == OFS_MODE_CTRL |=> !reg_rdata[0];
    endproperty
    property p_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    property p_fhi;
        reg_read && reg_addr == OFS_FILTER_HI |=> reg_rdata[7:4] == 4'h0;
    endproperty
    property p_half;
        bus_div_half;
    endproperty
    property p_byp;
        s_held(MODE_BYPASS_EXT) |-> !ref_osc_on && !digital_ctrl_osc_on;
    endproperty
    property p_self;
        s_held(MODE_SELF) |-> !ref_osc_on && digital_ctrl_osc_on;
    endproperty
    property p_int;
        s_held(MODE_LOCK_INT) |-> ref_osc_on && digital_ctrl_osc_on;
    endproperty
    property p_stat;
        reg_read && reg_addr == OFS_STATUS1 |=> reg_rdata[7:6] == $past(mode_actual);
    endproperty
    property p_irq;
        irq_pending && !clr && !$past(clr) && !$past(clr, 2) |=> irq_pending;
    endproperty
    a_mult: assert property (p_mult) else $error("mult factor wrong");
    a_div: assert property (p_div) else $error("div factor wrong");
    a_bit0: assert property (p_bit0) else $error("mode bit0 not zero");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_fhi: assert property (p_fhi) else $error("filter top bits set");
    a_half: assert property (p_half) else $error("bus not half");
    a_byp: assert property (p_byp) else $error("osc on in bypass");
    a_self: assert property (p_self) else $error("self osc state wrong");
    a_int: assert property (p_int) else $error("int osc state wrong");
    a_stat: assert property (p_stat) else $error("status mode wrong");
    a_irq: assert property (p_irq) else $error("irq dropped");
endmodule : clock_gen_unit_chk

bind clock_gen_unit clock_gen_unit_chk chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .mode_actual(mode_actual),
    .mult_factor(mult_factor), .div_factor(div_factor), .ref_osc_on(ref_osc_on),
    .digital_ctrl_osc_on(digital_ctrl_osc_on), .bus_div_half(bus_div_half),
    .irq_pending(irq_pending));

// *** dv/tb.sv ***
// testbench: directed scenarios for clock_gen_unit
// assumes settle count shortened to 2 cycles
`timescale 1ns/100ps
module tb;
    import clock_gen_unit_pkg::*;
    logic clk_sys, reset_n, reg_write, reg_read, ext_ok, locked, stable, up, dn;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, rdata, div_f, trim;
    logic [1:0] mode;
    logic [4:0] mult;
    logic [6:0] pre;
    logic ref_on, osc_on, closed, use_ext, ext_en, hg, half, llr, clr_p, irq;
    int n_fail, checks_done, cyc;
    `define CHK(a, b) check_eq(32'(a), 32'(b));

    clock_gen_unit #(.SETTLE(2)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(rdata), .ext_clock_ok(ext_ok),
        .osc_locked(locked), .osc_stable(stable), .filter_step_up(up),
        .filter_step_down(dn), .mode_actual(mode), .mult_factor(mult),
        .div_factor(div_f), .prescale(pre), .ref_osc_on(ref_on),
        .digital_ctrl_osc_on(osc_on), .loop_closed(closed), .use_ext_clock(use_ext),
        .ext_osc_enable(ext_en), .high_gain_select(hg), .bus_div_half(half),
        .lock_loss_reset(llr), .clock_loss_reset(clr_p), .irq_pending(irq),
        .trim_value(trim));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic void check_eq(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endfunction : check_eq
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd
    task automatic wait_mode(input logic [1:0] old, input logic [1:0] m);
        int i;
        @(posedge clk_sys);
        #1;
        `CHK(mode, old)
        for (i = 0; i < 60 && mode !== m; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK(mode, m)
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wait_mode
    task automatic wait_irq();
        int i;
        for (i = 0; i < 12 && irq !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1;
        `CHK({mode, ref_on, osc_on, half}, 5'h03)
        `CHK({mult, div_f, trim}, {5'h04, 8'h01, 8'h80})
        rd(OFS_FILTER_HI, 8'h00);
        rd(3'h7, 8'h00);
        rd(OFS_STATUS1, 8'h22);
        rd(OFS_STATUS2, 8'h01);
    endtask : t_reset
    task automatic t_ratio();
        for (int i = 0; i < 8; i++) begin
            wr(OFS_RATIO_CTRL, 8'((i << 4) | i));
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK({mult, div_f}, {5'(4 + 2 * i), 8'(1 << i)})
        end
    endtask : t_ratio
    task automatic t_lock_ext();
        wr(OFS_MODE_CTRL, 8'h79);
        wait_mode(MODE_SELF, MODE_LOCK_EXT);
        rd(OFS_MODE_CTRL, 8'h78);
        `CHK({ext_en, pre, closed}, {1'b1, 7'h01, 1'b1})
        rd(OFS_STATUS1, 8'hea);
        up <= 1'b1;
        repeat (3) @(posedge clk_sys);
        up <= 1'b0;
        dn <= 1'b1;
        @(posedge clk_sys);
        dn <= 1'b0;
        rd(OFS_FILTER_LO, 8'h02);
        wr(OFS_RATIO_CTRL, 8'h30);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK({mult, div_f}, {5'h0a, 8'h01})
    endtask : t_lock_ext
    task automatic t_lock_loss();
        locked <= 1'b0;
        wait_irq();
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK({irq, llr}, 2'b10)
        locked <= 1'b1;
        rd(OFS_STATUS1, 8'he7);
        wr(OFS_STATUS1, 8'h01);
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(irq, 1'b0)
        rd(OFS_STATUS1, 8'hea);
    endtask : t_lock_loss
    task automatic t_int();
        wr(OFS_MODE_CTRL, 8'h88);
        wait_mode(MODE_LOCK_EXT, MODE_LOCK_INT);
        rd(OFS_MODE_CTRL, 8'h28);
        `CHK({ref_on, osc_on, use_ext, hg, pre}, {4'b1100, 7'h40})
        wr(OFS_TRIM, 8'h7c);
        rd(OFS_TRIM, 8'h7c);
        `CHK(trim, 8'h7c)
    endtask : t_int
    task automatic t_bypass();
        int i;
        int seen;
        seen = 0;
        wr(OFS_RATIO_CTRL, 8'h08);
        wr(OFS_MODE_CTRL, 8'h10);
        wait_mode(MODE_LOCK_INT, MODE_BYPASS_EXT);
        `CHK({ref_on, osc_on, use_ext, div_f}, {3'b001, 8'h01})
        ext_ok <= 1'b0;
        for (i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            #1;
            if (clr_p === 1'b1) seen = 1;
        end
        `CHK({seen[0], irq, mode}, 4'b1100)
        wr(OFS_STATUS1, 8'h01);
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(irq, 1'b0)
    endtask : t_bypass

    // ------------------------------------------------------------
    // clock, reset, sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        {reset_n, reg_write, reg_read, up, dn} = '0;
        {ext_ok, locked, stable} = 3'b111;
        reg_addr = '0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_ratio();
        t_lock_ext();
        t_lock_loss();
        t_int();
        t_bypass();
        stop_test();
    end
endmodule : tb

// *** rtl/clock_gen_unit.sv ***
// clock generator mode selection, ratio decode, status and filter registers
// assumes external/osc status inputs from analog cells; ratio values drive synthesizer
`timescale 1ns/100ps
module clock_gen_unit
    import clock_gen_unit_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic ext_clock_ok,
    input wire logic osc_locked,
    input wire logic osc_stable,
    input wire logic filter_step_up,
    input wire logic filter_step_down,
    output logic [1:0] mode_actual,
    output logic [4:0] mult_factor,
    output logic [7:0] div_factor,
    output logic [6:0] prescale,
    output logic ref_osc_on,
    output logic digital_ctrl_osc_on,
    output logic loop_closed,
    output logic use_ext_clock,
    output logic ext_osc_enable,
    output logic high_gain_select,
    output logic bus_div_half,
    output logic lock_loss_reset,
    output logic clock_loss_reset,
    output logic irq_pending,
    output logic [7:0] trim_value
);

    typedef struct packed {
        logic [7:0] mode_ctrl;
        logic [7:0] ratio_ctrl;
        logic [11:0] filter;
        logic [7:0] trim;
        logic first_write_done;
        logic [1:0] actual;
        logic [15:0] settle_cnt;
        logic lock_lost;
        logic clk_lost;
        logic locked_prev;
        logic ext_prev;
        logic [7:0] rdata;
        logic [4:0] mult;
        logic [7:0] divf;
        logic [6:0] pre;
        logic ref_on;
        logic osc_on;
        logic closed;
        logic use_ext;
        logic lock_rst;
        logic clk_rst;
        logic half;
        logic irq;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [1:0] rst_sync_reg;
    logic rst_n_int;
    logic [2:0] in1_reg;
    logic [2:0] in2_reg;
    logic ext_ok_s;
    logic locked_s;
    logic stable_s;

    // --------------------------------------------------------------
    // reset release and input synchronisers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    always_ff @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            in1_reg <= 3'b000;
            in2_reg <= 3'b000;
        end else begin
            in1_reg <= {osc_stable, osc_locked, ext_clock_ok};
            in2_reg <= in1_reg;
        end
    end
    assign ext_ok_s = in2_reg[0];
    assign locked_s = in2_reg[1];
    assign stable_s = in2_reg[2];

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic [1:0] req;
        logic [1:0] target;
        logic ext_req;
        logic lock_fall;
        logic ext_fall;
        logic [7:0] wmode;
        st_next = st_reg;
        req = st_reg.mode_ctrl[MC_MODE_HI:MC_MODE_LO];
        ext_req = st_reg.mode_ctrl[MC_EXT_REF];
        lock_fall = st_reg.locked_prev && !locked_s && st_reg.closed;
        ext_fall = st_reg.ext_prev && !ext_ok_s && st_reg.use_ext;
        wmode = reg_wdata;
        target = st_reg.actual;

        // register writes
        if (reg_write) begin
            case (reg_addr)
                OFS_MODE_CTRL: begin
                    // external request and high gain fixed after first write
                    if (st_reg.first_write_done) begin
                        wmode[MC_EXT_REF] = st_reg.mode_ctrl[MC_EXT_REF];
                        wmode[MC_HIGH_GAIN] = st_reg.mode_ctrl[MC_HIGH_GAIN];
                    end
                    st_next.mode_ctrl = wmode & MODE_CTRL_RD_MASK;
                    st_next.first_write_done = 1'b1;
                end
                OFS_RATIO_CTRL: st_next.ratio_ctrl = reg_wdata;
                OFS_TRIM: st_next.trim = reg_wdata;
                default: ;
            endcase
        end

        if (reg_write && reg_addr == OFS_STATUS1 && reg_wdata[S1_IRQ]) begin
            st_next.lock_lost = 1'b0;
            st_next.clk_lost = 1'b0;
        end
        if (lock_fall) begin
            st_next.lock_lost = 1'b1;
        end
        if (ext_fall && !st_reg.mode_ctrl[MC_LOSS_OFF]) begin
            st_next.clk_lost = 1'b1;
        end
        st_next.locked_prev = locked_s;
        st_next.ext_prev = ext_ok_s;
        st_next.irq = st_next.lock_lost || st_next.clk_lost;
        st_next.half = 1'b1;

        // filter tracks loop only while closed
        if (st_reg.closed && filter_step_up && st_reg.filter != 12'hfff) begin
            st_next.filter = st_reg.filter + 12'h001;
        end else if (st_reg.closed && filter_step_down && st_reg.filter != 12'h000) begin
            st_next.filter = st_reg.filter - 12'h001;
        end

        // pick reachable target for the request
        case (req)
            MODE_SELF: target = MODE_SELF;
            MODE_LOCK_INT: target = stable_s ? MODE_LOCK_INT : MODE_SELF;
            MODE_BYPASS_EXT: target = (ext_req && ext_ok_s) ? MODE_BYPASS_EXT : MODE_SELF;
            // locked external needs reference and oscillator
            MODE_LOCK_EXT: begin
                if (ext_req && ext_ok_s && stable_s) begin
                    target = MODE_LOCK_EXT;
                end else if (ext_req && ext_ok_s) begin
                    target = MODE_BYPASS_EXT;
                end else begin
                    target = MODE_SELF;
                end
            end
            default: target = MODE_SELF;
        endcase
        // clock lost drops back to self-clocked at once
        if (st_reg.use_ext && !ext_ok_s) begin
            target = MODE_SELF;
            st_next.actual = MODE_SELF;
            st_next.settle_cnt = 16'h0000;
        end else if (target != st_reg.actual) begin
            if (st_reg.settle_cnt >= 16'(SETTLE - 1)) begin
                st_next.actual = target;
                st_next.settle_cnt = 16'h0000;
            end else begin
                st_next.settle_cnt = st_reg.settle_cnt + 16'h0001;
            end
        end else begin
            st_next.settle_cnt = 16'h0000;
        end

        st_next.mult = 5'(MULT_BASE) + 5'(MULT_STEP) * {2'b00, st_reg.ratio_ctrl[RC_MULT_HI:RC_MULT_LO]};
        st_next.divf = 8'h01 << st_reg.ratio_ctrl[RC_DIV_HI:RC_DIV_LO];

        case (st_next.actual)
            MODE_LOCK_INT: st_next.pre = 7'(LOW_RANGE_PRESCALE);
            MODE_LOCK_EXT: st_next.pre = st_reg.mode_ctrl[MC_RANGE]
                ? 7'(HIGH_RANGE_PRESCALE) : 7'(LOW_RANGE_PRESCALE);
            default: st_next.pre = 7'(HIGH_RANGE_PRESCALE);
        endcase

        case (st_next.actual)
            MODE_SELF: begin
                st_next.ref_on = 1'b0;
                st_next.osc_on = 1'b1;
                st_next.closed = 1'b0;
                st_next.use_ext = 1'b0;
            end
            MODE_LOCK_INT: begin
                st_next.ref_on = 1'b1;
                st_next.osc_on = 1'b1;
                st_next.closed = 1'b1;
                st_next.use_ext = 1'b0;
            end
            MODE_BYPASS_EXT: begin
                st_next.ref_on = 1'b0;
                st_next.osc_on = 1'b0;
                st_next.closed = 1'b0;
                st_next.use_ext = 1'b1;
            end
            default: begin
                st_next.ref_on = 1'b0;
                st_next.osc_on = 1'b1;
                st_next.closed = 1'b1;
                st_next.use_ext = 1'b1;
            end
        endcase

        // reset requests only when enable bits set
        st_next.lock_rst = lock_fall && st_reg.ratio_ctrl[RC_LOCK_RST];
        st_next.clk_rst = ext_fall && !st_reg.mode_ctrl[MC_LOSS_OFF]
            && st_reg.ratio_ctrl[RC_CLK_RST];

        // read path, data one cycle later
        st_next.rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                OFS_MODE_CTRL: st_next.rdata = st_reg.mode_ctrl & MODE_CTRL_RD_MASK;
                OFS_RATIO_CTRL: st_next.rdata = st_reg.ratio_ctrl;
                OFS_STATUS1: begin
                    st_next.rdata[S1_MODE_HI:S1_MODE_LO] = st_reg.actual;
                    st_next.rdata[S1_EXT_OK] = ext_ok_s;
                    st_next.rdata[S1_CLK_LOST] = st_reg.clk_lost;
                    st_next.rdata[S1_LOCKED] = locked_s && st_reg.closed;
                    st_next.rdata[S1_LOCK_LOST] = st_reg.lock_lost;
                    st_next.rdata[S1_REF_STABLE] = stable_s;
                    st_next.rdata[S1_IRQ] = st_reg.lock_lost || st_reg.clk_lost;
                end
                OFS_STATUS2: st_next.rdata[S2_OSC_STABLE] = stable_s;
                OFS_FILTER_HI: st_next.rdata = {4'h0, st_reg.filter[11:8]};
                OFS_FILTER_LO: st_next.rdata = st_reg.filter[7:0];
                OFS_TRIM: st_next.rdata = st_reg.trim;
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_reg <= '0;
            st_reg.actual <= MODE_SELF;
            st_reg.mode_ctrl <= MODE_CTRL_RST;
            st_reg.ratio_ctrl <= RATIO_CTRL_RST;
            st_reg.filter <= FILTER_RST;
            st_reg.trim <= TRIM_RST;
            st_reg.mult <= 5'(MULT_BASE);
            st_reg.divf <= 8'h01;
            st_reg.pre <= 7'(HIGH_RANGE_PRESCALE);
            st_reg.osc_on <= 1'b1;
            st_reg.half <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign mode_actual = st_reg.actual;
    assign mult_factor = st_reg.mult;
    assign div_factor = st_reg.divf;
    assign prescale = st_reg.pre;
    assign ref_osc_on = st_reg.ref_on;
    assign digital_ctrl_osc_on = st_reg.osc_on;
    assign loop_closed = st_reg.closed;
    assign use_ext_clock = st_reg.use_ext;
    assign ext_osc_enable = st_reg.mode_ctrl[MC_EXT_REF];
    assign high_gain_select = st_reg.mode_ctrl[MC_HIGH_GAIN];
    assign bus_div_half = st_reg.half;
    assign lock_loss_reset = st_reg.lock_rst;
    assign clock_loss_reset = st_reg.clk_rst;
    assign irq_pending = st_reg.irq;
    assign trim_value = st_reg.trim;

endmodule : clock_gen_unit
